// [design/spc_defs.vh]
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// register word indexes; byte address is four times the index
`define SPC_REG_CTRL 5'h00
`define SPC_REG_TGT_MIN 5'h01
`define SPC_REG_TGT_MAX 5'h02
`define SPC_REG_FB_MIN 5'h03
`define SPC_REG_FB_MAX 5'h04
`define SPC_REG_SETPOINT 5'h05
`define SPC_REG_DEAD_BAND 5'h06
`define SPC_REG_GAIN 5'h07
`define SPC_REG_ICOEF 5'h08
`define SPC_REG_DCOEF 5'h09
`define SPC_REG_ITIME 5'h0a
`define SPC_REG_DTIME 5'h0b
`define SPC_REG_LOOP_MS 5'h0c
`define SPC_REG_SET_LIM 5'h0d
`define SPC_REG_CLR_LIM 5'h0e
`define SPC_REG_STATUS 5'h0f
`define SPC_REG_RESULT 5'h10

// control register fields
`define SPC_CTRL_ENABLE 0
`define SPC_CTRL_ALGO 1
`define SPC_CTRL_LOGIC_LO 2
`define SPC_CTRL_LOGIC_HI 3
`define SPC_CTRL_IDLE_LO 4
`define SPC_CTRL_IDLE_HI 5
`define SPC_CTRL_DEF_DIR 6
`define SPC_CTRL_DELTA_LO 7
`define SPC_CTRL_DELTA_HI 9

// encodings
`define SPC_ALGO_TARGET 1'b0
`define SPC_ALGO_SETPOINT 1'b1
`define SPC_LOGIC_UNIDIR 2'h0
`define SPC_LOGIC_CW_UNDER 2'h1
`define SPC_LOGIC_CW_OVER 2'h2
`define SPC_IDLE_DISABLED 2'h0
`define SPC_IDLE_STOPPED 2'h1
`define SPC_IDLE_HOLDING 2'h2
`define SPC_MODE_DISABLED 2'h0
`define SPC_MODE_STOPPED 2'h1
`define SPC_MODE_HOLDING 2'h2
`define SPC_MODE_RUNNING 2'h3
`define SPC_DELTA_OFF 3'h0
`define SPC_DELTA_SGN_ABOVE 3'h1
`define SPC_DELTA_SGN_BELOW 3'h2
`define SPC_DELTA_ABS_ABOVE 3'h3
`define SPC_DELTA_ABS_BELOW 3'h4
`define SPC_DIR_CW 1'b1

// percent scale: 10000 counts = 100.00 %
`define SPC_FULL_PCT 16'h2710
`define SPC_GAIN_FRAC 8

// reset values (feedback in mV)
`define SPC_RST_CTRL 16'h0026
`define SPC_RST_FB_MAX 16'h1388
`define SPC_RST_TGT_MAX 16'h1388
`define SPC_RST_SETPOINT 16'h09c4
`define SPC_RST_DEAD_BAND 16'h0064
`define SPC_RST_GAIN 16'h0100
`define SPC_RST_LOOP_MS 16'h000a

// timing
`define SPC_CLK_PERIOD_NS 50
`define SPC_MS_IN_NS 1000000

`endif

// [design/spc_pid_speed.v]
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_pid_speed #(
	parameter CYCLES_PER_MS = `SPC_MS_IN_NS / `SPC_CLK_PERIOD_NS
) (
	input wire core_clk,
	input wire nrst,
	input wire [4:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire [15:0] target_in,
	input wire [15:0] feedback_in,
	input wire estop,
	input wire run_cmd,
	output reg [1:0] motor_mode,
	output reg motor_dir,
	output reg [15:0] step_rate_x,
	output reg delta_out_of_range
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	function [15:0] to_pct;
		input [15:0] x;
		input [15:0] lo;
		input [15:0] hi;
		reg [31:0] q;
		begin
			q = ({16'h0000, x} - {16'h0000, lo}) * {16'h0000, `SPC_FULL_PCT};
			if (hi <= lo || x <= lo) begin
				to_pct = 16'h0000;
			end else if (x >= hi) begin
				to_pct = `SPC_FULL_PCT;
			end else begin
				q = q / {16'h0000, hi - lo};
				to_pct = q[15:0];
			end
		end
	endfunction

	// a distance in feedback units, scaled with the feedback span
	function [15:0] span_pct;
		input [15:0] d;
		input [15:0] lo;
		input [15:0] hi;
		reg [31:0] q;
		begin
			q = {16'h0000, d} * {16'h0000, `SPC_FULL_PCT};
			if (hi <= lo) begin
				span_pct = 16'h0000;
			end else begin
				q = q / {16'h0000, hi - lo};
				span_pct = (q > {16'h0000, `SPC_FULL_PCT}) ? `SPC_FULL_PCT : q[15:0];
			end
		end
	endfunction

	function [16:0] abs17;
		input signed [16:0] v;
		begin
			abs17 = v[16] ? -v : v;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	reg [15:0] ctrl;
	reg [15:0] tgt_min;
	reg [15:0] tgt_max;
	reg [15:0] fb_min;
	reg [15:0] fb_max;
	reg [15:0] setpoint;
	reg [15:0] dead_band;
	reg [15:0] gain;
	reg [15:0] integral_coefficient;
	reg [15:0] derivative_coefficient;
	reg [15:0] integral_time;
	reg [15:0] derivative_time;
	reg [15:0] loop_ms;
	reg [15:0] set_limit;
	reg [15:0] clear_limit;
	reg [15:0] result;
	reg estop_lock;

	wire pid_enable = ctrl[`SPC_CTRL_ENABLE];
	wire algo = ctrl[`SPC_CTRL_ALGO];
	wire [1:0] direction_logic_select = ctrl[`SPC_CTRL_LOGIC_HI:`SPC_CTRL_LOGIC_LO];
	wire [1:0] idle_motor_behaviour = ctrl[`SPC_CTRL_IDLE_HI:`SPC_CTRL_IDLE_LO];
	wire default_dir = ctrl[`SPC_CTRL_DEF_DIR];
	wire [2:0] delta_flag_select = ctrl[`SPC_CTRL_DELTA_HI:`SPC_CTRL_DELTA_LO];

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `SPC_RST_CTRL;
			tgt_min <= 16'h0000;
			tgt_max <= `SPC_RST_TGT_MAX;
			fb_min <= 16'h0000;
			fb_max <= `SPC_RST_FB_MAX;
			setpoint <= `SPC_RST_SETPOINT;
			dead_band <= `SPC_RST_DEAD_BAND;
			gain <= `SPC_RST_GAIN;
			integral_coefficient <= 16'h0000;
			derivative_coefficient <= 16'h0000;
			integral_time <= 16'h0000;
			derivative_time <= 16'h0000;
			loop_ms <= `SPC_RST_LOOP_MS;
			set_limit <= 16'h0000;
			clear_limit <= 16'h0000;
		end else if (reg_wr) begin
			case (reg_addr)
				`SPC_REG_CTRL: ctrl <= reg_wdata;
				`SPC_REG_TGT_MIN: tgt_min <= reg_wdata;
				`SPC_REG_TGT_MAX: tgt_max <= reg_wdata;
				`SPC_REG_FB_MIN: fb_min <= reg_wdata;
				`SPC_REG_FB_MAX: fb_max <= reg_wdata;
				`SPC_REG_SETPOINT: setpoint <= reg_wdata;
				`SPC_REG_DEAD_BAND: dead_band <= reg_wdata;
				`SPC_REG_GAIN: gain <= reg_wdata;
				`SPC_REG_ICOEF: integral_coefficient <= reg_wdata;
				`SPC_REG_DCOEF: derivative_coefficient <= reg_wdata;
				`SPC_REG_ITIME: integral_time <= reg_wdata;
				`SPC_REG_DTIME: derivative_time <= reg_wdata;
				`SPC_REG_LOOP_MS: loop_ms <= reg_wdata;
				`SPC_REG_SET_LIM: set_limit <= reg_wdata;
				`SPC_REG_CLR_LIM: clear_limit <= reg_wdata;
				default: ctrl <= ctrl;
			endcase
		end
	end

	// read data valid the cycle after the strobe, zero otherwise
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (!reg_rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (reg_addr)
				`SPC_REG_CTRL: reg_rdata <= ctrl;
				`SPC_REG_TGT_MIN: reg_rdata <= tgt_min;
				`SPC_REG_TGT_MAX: reg_rdata <= tgt_max;
				`SPC_REG_FB_MIN: reg_rdata <= fb_min;
				`SPC_REG_FB_MAX: reg_rdata <= fb_max;
				`SPC_REG_SETPOINT: reg_rdata <= setpoint;
				`SPC_REG_DEAD_BAND: reg_rdata <= dead_band;
				`SPC_REG_GAIN: reg_rdata <= gain;
				`SPC_REG_ICOEF: reg_rdata <= integral_coefficient;
				`SPC_REG_DCOEF: reg_rdata <= derivative_coefficient;
				`SPC_REG_ITIME: reg_rdata <= integral_time;
				`SPC_REG_DTIME: reg_rdata <= derivative_time;
				`SPC_REG_LOOP_MS: reg_rdata <= loop_ms;
				`SPC_REG_SET_LIM: reg_rdata <= set_limit;
				`SPC_REG_CLR_LIM: reg_rdata <= clear_limit;
				`SPC_REG_STATUS: reg_rdata <= {11'h000, estop_lock, delta_out_of_range, motor_dir, motor_mode};
				`SPC_REG_RESULT: reg_rdata <= result;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// normalisation and error

	wire [15:0] fb_pct = to_pct(feedback_in, fb_min, fb_max);
	wire [15:0] tgt_src_pct = to_pct(target_in, tgt_min, tgt_max);
	wire [15:0] sp_pct = to_pct(setpoint, fb_min, fb_max);
	wire [15:0] tgt_pct = (algo == `SPC_ALGO_SETPOINT) ? sp_pct : tgt_src_pct;
	wire [15:0] band_pct = span_pct(dead_band, fb_min, fb_max);
	wire [15:0] set_pct = span_pct(set_limit, fb_min, fb_max);
	wire [15:0] clr_pct = span_pct(clear_limit, fb_min, fb_max);

	wire signed [16:0] delta = $signed({1'b0, tgt_pct}) - $signed({1'b0, fb_pct});
	wire [16:0] delta_mag = abs17(delta);
	wire in_band = delta_mag < {1'b0, band_pct};
	wire signed [16:0] err = in_band ? 17'sh0_0000 : delta;

	////////////////////////////////////////////////////////////////////////////
	// gains and controller arithmetic (Q8.8 gains)

	reg signed [23:0] err_sum;
	reg signed [16:0] err_prev;

	// interval and time constants share the ms unit, so period/itime reduces to loop_ms/itime
	wire [31:0] g_ki = gain * integral_coefficient;
	wire [31:0] g_kd = gain * derivative_coefficient;
	wire [47:0] i_num = {16'h0000, g_ki} * {32'h0000_0000, loop_ms};
	wire [47:0] d_num = {16'h0000, g_kd} * {32'h0000_0000, derivative_time};
	wire [47:0] i_gain_w = (integral_time == 16'h0000) ? 48'h0000_0000_0000 :
		(i_num >> `SPC_GAIN_FRAC) / {32'h0000_0000, integral_time};
	wire [47:0] d_gain_w = (loop_ms == 16'h0000) ? 48'h0000_0000_0000 :
		(d_num >> `SPC_GAIN_FRAC) / {32'h0000_0000, loop_ms};
	// large gains are clipped rather than wrapped
	wire [22:0] i_gain = (i_gain_w[47:23] != 25'h000_0000) ? 23'h7f_ffff : i_gain_w[22:0];
	wire [22:0] d_gain = (d_gain_w[47:23] != 25'h000_0000) ? 23'h7f_ffff : d_gain_w[22:0];

	// running sum, limited to the 24-bit range
	wire signed [24:0] sum_wide = {err_sum[23], err_sum} + {{8{err[16]}}, err};
	wire signed [23:0] sum_next = (sum_wide[24] != sum_wide[23]) ?
		(sum_wide[24] ? 24'sh80_0000 : 24'sh7f_ffff) : sum_wide[23:0];
	wire signed [17:0] err_diff = {err[16], err} - {err_prev[16], err_prev};

	wire signed [47:0] p_term = {{31{err[16]}}, err} * $signed({32'h0000_0000, gain});
	wire signed [47:0] i_term = {{24{sum_next[23]}}, sum_next} * $signed({25'h000_0000, i_gain});
	wire signed [47:0] d_term = {{30{err_diff[17]}}, err_diff} * $signed({25'h000_0000, d_gain});
	wire signed [47:0] pid_sum = p_term + i_term + d_term;
	wire signed [47:0] pid_raw = pid_sum >>> `SPC_GAIN_FRAC;
	// push-pull takes the magnitude, direction carries the sign
	wire signed [47:0] pid_mag = (direction_logic_select != `SPC_LOGIC_UNIDIR && pid_raw < 0) ?
		-pid_raw : pid_raw;

	reg [15:0] pid_sat;
	always @* begin
		if (pid_mag < 0) begin
			pid_sat = 16'h0000;
		end else if (pid_mag > $signed({32'h0000_0000, `SPC_FULL_PCT})) begin
			pid_sat = `SPC_FULL_PCT;
		end else begin
			pid_sat = pid_mag[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// loop timer

	reg [31:0] cyc_cnt;
	reg [15:0] ms_cnt;
	wire ms_tick = (cyc_cnt == CYCLES_PER_MS - 1);
	wire loop_tick = ms_tick && (ms_cnt + 16'h0001 >= loop_ms);

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cyc_cnt <= 32'h0000_0000;
			ms_cnt <= 16'h0000;
		end else if (!pid_enable) begin
			cyc_cnt <= 32'h0000_0000;
			ms_cnt <= 16'h0000;
		end else if (ms_tick) begin
			cyc_cnt <= 32'h0000_0000;
			ms_cnt <= loop_tick ? 16'h0000 : ms_cnt + 16'h0001;
		end else begin
			cyc_cnt <= cyc_cnt + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// emergency stop lock

	reg run_cmd_q;
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			run_cmd_q <= 1'b0;
			estop_lock <= 1'b0;
		end else begin
			run_cmd_q <= run_cmd;
			// released only by a stopped-to-running edge once the stop is gone
			if (estop) begin
				estop_lock <= 1'b1;
			end else if (run_cmd && !run_cmd_q) begin
				estop_lock <= 1'b0;
			end
		end
	end
	wire halted = estop || estop_lock;

	////////////////////////////////////////////////////////////////////////////
	// controller state and motor commands

	reg [1:0] next_mode;
	reg next_dir;
	always @* begin
		next_mode = motor_mode;
		next_dir = motor_dir;
		if (direction_logic_select == `SPC_LOGIC_UNIDIR) begin
			next_dir = default_dir;
			next_mode = `SPC_MODE_RUNNING;
		end else if (in_band) begin
			case (idle_motor_behaviour)
				`SPC_IDLE_DISABLED: next_mode = `SPC_MODE_DISABLED;
				`SPC_IDLE_STOPPED: next_mode = `SPC_MODE_STOPPED;
				default: next_mode = `SPC_MODE_HOLDING;
			endcase
		end else begin
			next_mode = `SPC_MODE_RUNNING;
			if (direction_logic_select == `SPC_LOGIC_CW_UNDER) begin
				next_dir = delta[16] ? ~`SPC_DIR_CW : `SPC_DIR_CW;
			end else begin
				next_dir = delta[16] ? `SPC_DIR_CW : ~`SPC_DIR_CW;
			end
		end
		if (!pid_enable || halted) begin
			next_mode = `SPC_MODE_DISABLED;
		end
	end

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			err_sum <= 24'sh00_0000;
			err_prev <= 17'sh0_0000;
			result <= 16'h0000;
			motor_mode <= `SPC_MODE_DISABLED;
			motor_dir <= `SPC_DIR_CW;
			step_rate_x <= 16'h0000;
		end else if (!pid_enable) begin
			err_sum <= 24'sh00_0000;
			err_prev <= 17'sh0_0000;
			result <= 16'h0000;
			motor_mode <= `SPC_MODE_DISABLED;
			step_rate_x <= 16'h0000;
		end else begin
			if (halted) begin
				motor_mode <= `SPC_MODE_DISABLED;
				step_rate_x <= 16'h0000;
			end
			if (loop_tick) begin
				motor_mode <= next_mode;
				motor_dir <= next_dir;
				if (in_band && direction_logic_select == `SPC_LOGIC_UNIDIR) begin
					step_rate_x <= halted ? 16'h0000 : result;
				end else if (in_band) begin
					// reset the function, zero step rate; clear history
					err_sum <= 24'sh00_0000;
					err_prev <= 17'sh0_0000;
					result <= 16'h0000;
					step_rate_x <= 16'h0000;
				end else begin
					err_sum <= sum_next;
					err_prev <= err;
					result <= pid_sat;
					step_rate_x <= halted ? 16'h0000 : pid_sat;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// delta out-of-range flag

	wire signed [16:0] set_s = $signed({1'b0, set_pct});
	wire signed [16:0] clr_s = $signed({1'b0, clr_pct});
	wire signed [16:0] mag_s = $signed(delta_mag);

	// hysteresis between set and clear limits
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			delta_out_of_range <= 1'b0;
		end else begin
			case (delta_flag_select)
				`SPC_DELTA_SGN_ABOVE: begin
					if (delta > set_s) delta_out_of_range <= 1'b1;
					else if (delta < clr_s) delta_out_of_range <= 1'b0;
				end
				`SPC_DELTA_SGN_BELOW: begin
					if (delta < set_s) delta_out_of_range <= 1'b1;
					else if (delta > clr_s) delta_out_of_range <= 1'b0;
				end
				`SPC_DELTA_ABS_ABOVE: begin
					if (mag_s > set_s) delta_out_of_range <= 1'b1;
					else if (mag_s < clr_s) delta_out_of_range <= 1'b0;
				end
				`SPC_DELTA_ABS_BELOW: begin
					if (mag_s < set_s) delta_out_of_range <= 1'b1;
					else if (mag_s > clr_s) delta_out_of_range <= 1'b0;
				end
				default: delta_out_of_range <= 1'b0;
			endcase
		end
	end

endmodule

// [test/spc_pid_speed_assertions.sv]
`timescale 1ns/1ps
module spc_pid_chk #(
	parameter CYCLES_PER_MS = 20000
) (
	input wire core_clk,
	input wire nrst,
	input wire [4:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire [15:0] target_in,
	input wire [15:0] feedback_in,
	input wire estop,
	input wire run_cmd,
	input wire [1:0] motor_mode,
	input wire motor_dir,
	input wire [15:0] step_rate_x,
	input wire delta_out_of_range
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	localparam int BIG = 1000000;
	int gap;
	logic [2:0] cause;
	////////////////////
	// gap counts cycles since the result last moved to a nonzero value
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gap <= BIG;
			cause <= 3'h0;
		end else begin
			gap <= ($changed(step_rate_x) && step_rate_x != 16'h0000) ? 0 : (gap < BIG ? gap + 1 : gap);
			cause <= {cause[1:0], reg_wr || $changed(target_in) || $changed(feedback_in)};
		end
	end
	////////////////////
	estop_halt_a: assert property (estop |=> motor_mode == 2'h0 && step_rate_x == 16'h0000)
		else $error("drive still active after emergency stop");
	estop_lock_a: assert property (estop ##1 (!estop && !$rose(run_cmd)) |=> motor_mode == 2'h0)
		else $error("drive left lock without a run command edge");
	step_range_a: assert property (step_rate_x <= 16'h2710)
		else $error("result above full scale");
	idle_zero_a: assert property (motor_mode != 2'h3 |-> step_rate_x == 16'h0000)
		else $error("nonzero step rate while not running");
	reset_out_a: assert property ($rose(nrst) |-> motor_mode == 2'h0 && motor_dir && step_rate_x == 16'h0000 && !delta_out_of_range)
		else $error("outputs wrong after reset");
	iter_gap_a: assert property ($changed(step_rate_x) && step_rate_x != 16'h0000 |-> gap >= CYCLES_PER_MS - 1)
		else $error("result updated faster than the loop interval");
	flag_cause_a: assert property ($changed(delta_out_of_range) |-> cause != 3'h0)
		else $error("range flag moved with no input change");
	read_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	cover property (estop ##1 !estop);
	cover property ($rose(delta_out_of_range));
	cover property (motor_mode == 2'h3 ##1 motor_mode == 2'h2);
endmodule

bind spc_pid_speed spc_pid_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (.core_clk(core_clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.target_in(target_in), .feedback_in(feedback_in), .estop(estop), .run_cmd(run_cmd),
	.motor_mode(motor_mode), .motor_dir(motor_dir), .step_rate_x(step_rate_x),
	.delta_out_of_range(delta_out_of_range));

// [test/spc_drive_model.sv]
`timescale 1ns/1ps
module spc_drive_model (
	input wire core_clk,
	input wire nrst,
	input wire [15:0] fb_level,
	output logic [15:0] feedback_in
);
	// sensor value arrives one cycle late, as a sampled input would
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			feedback_in <= 16'h0000;
		else
			feedback_in <= fb_level;
	end
endmodule

// [test/test_pid_stepper_speed_control.sv]
`timescale 1ns/1ps
`include "spc_defs.vh"
module test_pid_stepper_speed_control;
	localparam int CPM = 4;
	localparam int BAND = 200;
	logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, estop = 0, run_cmd = 1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, target_in = 16'h0000, fb_level = 16'h0000, rv;
	wire [15:0] reg_rdata, feedback_in, step_rate_x;
	wire [1:0] motor_mode;
	wire motor_dir, delta_out_of_range;
	int bad_count = 0, checked = 0, ticks = 0, e, t, f;
	logic [15:0] rst_val [18] = '{16'h0026, 16'h0000, 16'h1388, 16'h0000, 16'h1388, 16'h09c4, 16'h0064,
		16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0000, 16'h0000, 16'h0004, 16'h0000,
		16'h0000};
	// set above clear for codes 0, 1 and 3
	int dtab [5][6] = '{'{1, 400, 200, 2000, 2200, 2400}, '{2, 200, 400, 2400, 2200, 2000},
		'{3, 400, 200, 3000, 2800, 2600}, '{4, 200, 400, 2600, 2800, 3000}, '{0, 400, 200, 2000, 2200, 2400}};
	int seq [5] = '{5, 3, 4, 5, 4};
	bit flg [5] = '{0, 1, 1, 0, 0};

	spc_pid_speed #(.CYCLES_PER_MS(CPM)) dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .target_in(target_in),
		.feedback_in(feedback_in), .estop(estop), .run_cmd(run_cmd), .motor_mode(motor_mode),
		.motor_dir(motor_dir), .step_rate_x(step_rate_x), .delta_out_of_range(delta_out_of_range));
	spc_drive_model far (.core_clk(core_clk), .nrst(nrst), .fb_level(fb_level), .feedback_in(feedback_in));

	initial forever #25 core_clk = ~core_clk;
	////////////////////
	task automatic report_and_stop();
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		ticks <= ticks + 1;
		if (ticks == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic apply(input logic [15:0] fb, input logic [15:0] tg, input int n);
		@(posedge core_clk);
		fb_level <= fb;
		target_in <= tg;
		cyc(n);
	endtask
	function automatic logic [15:0] ctl(input logic [1:0] lg, input logic [1:0] idl, input logic al,
		input logic dr, input logic [2:0] dl);
		return {6'h00, dl, dr, idl, lg, al, 1'b1};
	endfunction
	task automatic trio(input logic [1:0] m, input logic d, input logic [15:0] s);
		chk({14'h0000, motor_mode}, {14'h0000, m});
		chk({15'h0000, motor_dir}, {15'h0000, d});
		chk(step_rate_x, s);
	endtask
	// push-pull expectation from the percent error and a Q8.8 gain
	task automatic look(input int err, input int g, input logic [1:0] lg, input logic [1:0] idl);
		int m;
		m = err < 0 ? -err : err;
		if (m < BAND) begin
			chk(step_rate_x, 16'h0000);
			chk({14'h0000, motor_mode}, {14'h0000, idl});
		end else begin
			m = m * g / 256;
			trio(`SPC_MODE_RUNNING, (err > 0) == (lg == `SPC_LOGIC_CW_UNDER), m > 10000 ? 16'h2710 : m[15:0]);
		end
	endtask
	////////////////////
	initial begin
		void'($urandom(32'h5ffa_0dc2));
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		cyc(1);
		trio(`SPC_MODE_DISABLED, 1'b1, 16'h0000);
		for (int i = 0; i < 18; i++) begin
			rd(i == 17 ? 5'h1f : 5'(i), rv);
			chk(rv, rst_val[i]);
		end
		wr(`SPC_REG_STATUS, 16'hffff);
		wr(5'h1f, 16'hffff);
		rd(`SPC_REG_STATUS, rv);
		chk(rv, 16'h0004);
		wr(`SPC_REG_LOOP_MS, 16'h0001);
		wr(`SPC_REG_CTRL, 16'h0027);
		apply(16'h099c, 16'h0000, 12);
		look(80, 256, 2'h1, 2'h2);
		apply(16'h07d0, 16'h0000, 12);
		look(1000, 256, 2'h1, 2'h2);
		// integral and derivative left at zero for push-pull
		wr(`SPC_REG_TGT_MIN, 16'h03e8);
		wr(`SPC_REG_TGT_MAX, 16'h0bb8);
		for (int i = 0; i < 12; i++) begin
			t = $urandom_range(3000, 1000);
			f = i == 1 ? 2400 : i == 3 ? 2401 : $urandom_range(5000, 0);
			wr(`SPC_REG_CTRL, ctl(2'(1 + i[1]), 2'h1, i[0], 1'b0, 3'h0));
			apply(16'(f), 16'(t), 12);
			e = i[0] ? 5000 - 2 * f : 5 * (t - 1000) - 2 * f;
			look(e, 256, 2'(1 + i[1]), 2'h1);
		end
		for (int i = 0; i < 3; i++) begin
			wr(`SPC_REG_CTRL, ctl(2'h1, 2'(i), 1'b1, 1'b0, 3'h0));
			apply(16'h099c, 16'h0000, 12);
			look(80, 256, 2'h1, 2'(i));
		end
		for (int d = 0; d < 2; d++) begin
			wr(`SPC_REG_CTRL, ctl(`SPC_LOGIC_UNIDIR, 2'h2, 1'b1, d[0], 3'h0));
			apply(16'h05dc, 16'h0000, 12);
			trio(`SPC_MODE_RUNNING, d[0], 16'h07d0);
			apply(16'h099c, 16'h0000, 12);
			trio(`SPC_MODE_RUNNING, d[0], 16'h07d0);
			apply(16'h0bb8, 16'h0000, 12);
			trio(`SPC_MODE_RUNNING, d[0], 16'h0000);
		end
		wr(`SPC_REG_GAIN, 16'h0300);
		wr(`SPC_REG_CTRL, ctl(2'h1, 2'h1, 1'b1, 1'b0, 3'h0));
		apply(16'h01f4, 16'h0000, 12);
		look(4000, 768, 2'h1, 2'h1);
		wr(`SPC_REG_GAIN, 16'h0100);
		apply(16'h05dc, 16'h0000, 12);
		@(posedge core_clk);
		estop <= 1'b1;
		cyc(2);
		chk(step_rate_x, 16'h0000);
		rd(`SPC_REG_STATUS, rv);
		chk(rv & 16'h0013, 16'h0010);
		@(posedge core_clk);
		estop <= 1'b0;
		cyc(12);
		chk({14'h0000, motor_mode}, 16'h0000);
		@(posedge core_clk);
		run_cmd <= 1'b0;
		repeat (2) @(posedge core_clk);
		run_cmd <= 1'b1;
		cyc(12);
		trio(`SPC_MODE_RUNNING, 1'b1, 16'h07d0);
		wr(`SPC_REG_CTRL, ctl(2'h1, 2'h1, 1'b1, 1'b0, 3'h0) & 16'hfffe);
		cyc(2);
		trio(`SPC_MODE_DISABLED, 1'b1, 16'h0000);
		wr(`SPC_REG_LOOP_MS, 16'h0002);
		wr(`SPC_REG_CTRL, ctl(2'h1, 2'h1, 1'b1, 1'b0, 3'h0));
		cyc(6);
		chk(step_rate_x, 16'h0000);
		cyc(4);
		chk(step_rate_x, 16'h07d0);
		rd(`SPC_REG_RESULT, rv);
		chk(rv, 16'h07d0);
		wr(`SPC_REG_LOOP_MS, 16'h0001);
		foreach (dtab[r]) begin
			wr(`SPC_REG_SET_LIM, 16'(dtab[r][1]));
			wr(`SPC_REG_CLR_LIM, 16'(dtab[r][2]));
			wr(`SPC_REG_CTRL, ctl(2'h1, 2'h1, 1'b1, 1'b0, 3'(dtab[r][0])));
			for (int k = 0; k < 5; k++) begin
				apply(16'(dtab[r][seq[k]]), 16'h0000, 4);
				chk({15'h0000, delta_out_of_range}, {15'h0000, dtab[r][0] != 0 && flg[k]});
			end
		end
		report_and_stop();
	end
endmodule
